// ---- hdl/sbc_pkg.sv ----
// Constants shared by the backplane memory card front end.
// Assumes bus pins arrive unsynchronised and are sampled on clk_i.
package sbc_pkg;

  localparam int SYNC_STAGES = 3;
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 8;
  localparam int NIB_W       = 4;
  localparam int PAGE_W      = 2;
  localparam int ROW_W       = 8;
  localparam int MEM_AW      = 18;

  // Positions of the control strobes inside the sampled pin vector
  localparam int CTL_MCSYNC  = 0;
  localparam int CTL_MEMREQ  = 1;
  localparam int CTL_RD      = 2;
  localparam int CTL_WR      = 3;
  localparam int CTL_REFRESH = 4;
  localparam int CTL_BUSAK   = 5;
  localparam int CTL_INTAK   = 6;
  localparam int CTL_PCI     = 7;
  localparam int CTL_BUSCLK  = 8;
  localparam int CTL_W       = 9;

  localparam int PIN_W       = CTL_W + ADDR_W + DATA_W;
  localparam int ADDR_LSB    = CTL_W;
  localparam int DATA_LSB    = CTL_W + ADDR_W;

  // Strobes idle high, priority chain and bus clock idle low
  localparam logic [CTL_W-1:0]  CTL_RESET  = 9'h07f;
  localparam logic [PIN_W-1:0]  PIN_RESET  = {{(DATA_W + ADDR_W){1'b0}}, CTL_RESET};
  localparam logic [NIB_W-1:0]  NIB_RESET  = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [ROW_W-1:0]  ROW_RESET  = 8'h00;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_RDWAIT = 6'h02,
    ST_RDDRV  = 6'h04,
    ST_WRITE  = 6'h08,
    ST_REF    = 6'h10,
    ST_VEC    = 6'h20
  } sbc_state_type;

endpackage

// ---- hdl/sbc_mem.sv ----
// Byte-wide storage array of the memory card.
// Assumes one clock; read data appear one cycle after the read enable.
`timescale 1ns/1ps
`default_nettype none
module sbc_mem #(
  parameter int AW = 18,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          clk_i,
  // Access port
  input  wire logic          re_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] store [0:(1<<AW)-1];

  // No reset: the array models dynamic cells whose contents are undefined at power-up
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      store[addr_i] <= wdata_i;
    end
    if (re_i) begin
      rdata_o <= store[addr_i];
    end
  end

endmodule
`default_nettype wire

// ---- hdl/sbc_card.sv ----
// Backplane memory card front end: page decode, read/write, refresh, interrupt chain.
// Assumes the CPU card owns the bus timing; every bus pin is asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module sbc_card
  import sbc_pkg::*;
#(
  parameter int MEM_ADDR_W = MEM_AW
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  // Bus address, data and strobes
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   data_i,
  output logic      [DATA_W-1:0]   data_o,
  output logic                     data_oe_o,
  input  wire logic                mcsync_n_i,
  input  wire logic                memreq_n_i,
  input  wire logic                rd_n_i,
  input  wire logic                wr_n_i,
  input  wire logic                refresh_n_i,
  input  wire logic                bus_clock_n_i,
  // Bus handshakes, open-drain requests and priority chain
  input  wire logic                busak_n_i,
  input  wire logic                intak_n_i,
  output logic                     waitrq_n_o,
  output logic                     waitrq_oe_o,
  output logic                     intrq_n_o,
  output logic                     intrq_oe_o,
  input  wire logic                pci_i,
  output logic                     pco_o,
  // Card side: page strap, interrupt source, bus mastering
  input  wire logic                card_en_i,
  input  wire logic [PAGE_W-1:0]   page_sel_i,
  input  wire logic                irq_i,
  input  wire logic [DATA_W-1:0]   vector_i,
  input  wire logic                service_done_i,
  input  wire logic                dma_req_i,
  output logic                     bus_grant_o,
  output logic                     refresh_pulse_o,
  output logic      [ROW_W-1:0]    refresh_row_o
);

  // A pin change counts once the second and third stages agree
  function automatic logic [PIN_W-1:0] settle(input logic [PIN_W-1:0] s2,
                                              input logic [PIN_W-1:0] s3,
                                              input logic [PIN_W-1:0] held);
    settle = (s2 & ~(s2 ^ s3)) | (held & (s2 ^ s3));
  endfunction

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] pin;
  logic             busclk_q;

  assign pin_raw = {data_i, addr_i, bus_clock_n_i, pci_i, intak_n_i, busak_n_i,
                    refresh_n_i, wr_n_i, rd_n_i, memreq_n_i, mcsync_n_i};

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1    <= PIN_RESET;
      sync2    <= PIN_RESET;
      sync3    <= PIN_RESET;
      pin      <= PIN_RESET;
      busclk_q <= 1'b0;
    end else begin
      sync1    <= pin_raw;
      sync2    <= sync1;
      sync3    <= sync2;
      pin      <= settle(sync2, sync3, pin);
      busclk_q <= pin[CTL_BUSCLK];
    end
  end

  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_data;
  logic              bus_tick;
  logic              memreq;
  logic              rd;
  logic              wr;
  logic              refresh;
  logic              intak;
  logic              busak;
  logic              pci;

  assign bus_addr = pin[ADDR_LSB +: ADDR_W];
  assign bus_data = pin[DATA_LSB +: DATA_W];
  // Strobes are judged at the rising edge of the inverted bus clock, when they are settled
  assign bus_tick = pin[CTL_BUSCLK] & ~busclk_q;
  assign memreq   = ~pin[CTL_MEMREQ];
  assign rd       = ~pin[CTL_RD];
  assign wr       = ~pin[CTL_WR];
  assign refresh  = ~pin[CTL_REFRESH];
  assign intak    = ~pin[CTL_INTAK];
  assign busak    = ~pin[CTL_BUSAK];
  assign pci      = pin[CTL_PCI];

  sbc_state_type     state;
  sbc_state_type     next_state;
  logic [NIB_W-1:0]  hi_nib;
  logic [NIB_W-1:0]  next_hi_nib;
  logic              in_service;
  logic              next_in_service;
  logic [DATA_W-1:0] next_data;
  logic              next_data_oe;
  logic              next_wait;
  logic              next_intrq;
  logic              next_pco;
  logic              next_grant;
  logic              next_ref_pulse;
  logic [ROW_W-1:0]  next_ref_row;
  logic              page_hit;
  logic              mem_re;
  logic              mem_we;
  logic [DATA_W-1:0] mem_rdata;
  logic [MEM_ADDR_W-1:0] mem_addr;

  assign page_hit = card_en_i && (hi_nib[NIB_W-1 -: PAGE_W] == page_sel_i);
  assign mem_addr = MEM_ADDR_W'({hi_nib[NIB_W-PAGE_W-1:0], bus_addr});

  always_comb begin
    next_state      = state;
    next_hi_nib     = hi_nib;
    next_data       = data_o;
    next_data_oe    = 1'b0;
    next_ref_pulse  = 1'b0;
    next_ref_row    = refresh_row_o;
    mem_re          = 1'b0;
    mem_we          = 1'b0;
    if (!pin[CTL_MCSYNC]) begin
      next_hi_nib = bus_data[NIB_W-1:0];
    end
    case (state)
      ST_IDLE: begin
        if (bus_tick && memreq && refresh) begin
          next_state     = ST_REF;
          next_ref_pulse = 1'b1;
          next_ref_row   = bus_addr[ROW_W-1:0];
        end else if (bus_tick && memreq && page_hit && rd) begin
          next_state = ST_RDWAIT;
          mem_re     = 1'b1;
        end else if (bus_tick && memreq && page_hit && wr) begin
          next_state = ST_WRITE;
          mem_we     = 1'b1;
        end else if (bus_tick && intak && irq_i && pci && !in_service) begin
          next_state   = ST_VEC;
          next_data    = vector_i;
          next_data_oe = 1'b1;
        end
      end
      ST_RDWAIT: begin
        next_state   = ST_RDDRV;
        next_data    = mem_rdata;
        next_data_oe = 1'b1;
      end
      ST_RDDRV: begin
        next_data_oe = memreq && rd;
        if (!next_data_oe) begin
          next_state = ST_IDLE;
        end
      end
      ST_WRITE, ST_REF: begin
        if (!memreq) begin
          next_state = ST_IDLE;
        end
      end
      ST_VEC: begin
        next_data_oe = intak;
        if (!intak) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Set wins over a clear that lands in the same cycle
    next_in_service = (in_service && !service_done_i) || (state == ST_VEC);
    next_wait       = (next_state == ST_RDWAIT);
    next_intrq      = irq_i && pci && !in_service;
    next_pco        = pci && !in_service;
    next_grant      = dma_req_i && busak;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state           <= ST_IDLE;
      hi_nib          <= NIB_RESET;
      in_service      <= 1'b0;
      data_o          <= DATA_RESET;
      data_oe_o       <= 1'b0;
      waitrq_n_o      <= 1'b0;
      waitrq_oe_o     <= 1'b0;
      intrq_n_o       <= 1'b0;
      intrq_oe_o      <= 1'b0;
      pco_o           <= 1'b0;
      bus_grant_o     <= 1'b0;
      refresh_pulse_o <= 1'b0;
      refresh_row_o   <= ROW_RESET;
    end else begin
      state           <= next_state;
      hi_nib          <= next_hi_nib;
      in_service      <= next_in_service;
      data_o          <= next_data;
      data_oe_o       <= next_data_oe;
      waitrq_n_o      <= 1'b0;
      waitrq_oe_o     <= next_wait;
      intrq_n_o       <= 1'b0;
      intrq_oe_o      <= next_intrq;
      pco_o           <= next_pco;
      bus_grant_o     <= next_grant;
      refresh_pulse_o <= next_ref_pulse;
      refresh_row_o   <= next_ref_row;
    end
  end

  sbc_mem #(
    .AW (MEM_ADDR_W),
    .DW (DATA_W)
  ) u_mem (
    .clk_i   (clk_i),
    .re_i    (mem_re),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .wdata_i (bus_data),
    .rdata_o (mem_rdata)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_GRANT_NEEDS_BUSAK: assert property (
    bus_grant_o |-> $past(busak) && $past(dma_req_i))
    else $error("bus grant without bus acknowledge");

  AST_VECTOR_ON_ACK: assert property (
    (state == ST_IDLE && next_state == ST_VEC) |=> data_oe_o && data_o == $past(vector_i))
    else $error("vector not driven on acknowledge");

  AST_VECTOR_RELEASE: assert property (
    (state == ST_VEC && !intak) |=> !data_oe_o && state == ST_IDLE)
    else $error("vector held after acknowledge ended");

  AST_WAIT_ON_READ: assert property (
    (state == ST_IDLE && mem_re) |=> waitrq_oe_o && !data_oe_o ##1 !waitrq_oe_o && data_oe_o)
    else $error("wait request not held until read data drive");

  AST_PCO_BLOCKED: assert property (
    in_service |=> !pco_o)
    else $error("chain output high while in service");

  AST_INTRQ_NEEDS_PCI: assert property (
    intrq_oe_o |-> $past(pci))
    else $error("interrupt requested with chain input low");

  AST_REFRESH_ROW: assert property (
    (state == ST_IDLE && bus_tick && memreq && refresh)
      |=> refresh_pulse_o && refresh_row_o == $past(bus_addr[ROW_W-1:0]) && !data_oe_o
      ##1 !refresh_pulse_o)
    else $error("refresh row not captured");

  AST_NIBBLE_LATCH: assert property (
    !pin[CTL_MCSYNC] |=> hi_nib == $past(bus_data[NIB_W-1:0]))
    else $error("high nibble not latched on sync strobe");

  COV_READ:    cover property (state == ST_RDWAIT ##1 state == ST_RDDRV);
  COV_WRITE:   cover property (state == ST_IDLE ##1 state == ST_WRITE);
  COV_REFRESH: cover property (refresh_pulse_o);
  COV_VECTOR:  cover property (state == ST_VEC ##1 in_service);

endmodule
`default_nettype wire

// ---- testbench/sbc_cpu_model.sv ----
// CPU card model: makes the bus clock and runs memory, refresh and acknowledge cycles.
// Assumes the bench resolves the shared data bus and the pulled-up wait line.
`timescale 1ns/1ps
`default_nettype none
module sbc_cpu_model (
  // Bus outputs of the master
  output logic            bus_clock_n_o,
  output logic [15:0]     addr_o,
  output logic [7:0]      data_o,
  output logic            mcsync_n_o,
  output logic            memreq_n_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic            refresh_n_o,
  output logic            busak_n_o,
  output logic            intak_n_o,
  // Bus inputs of the master
  input  wire logic [7:0] data_i,
  input  wire logic       waitrq_n_i
);
  logic [7:0] dval;
  logic       den;

  // Released data lines show the inverse, so a stale byte never passes for an answer
  assign data_o = den ? dval : ~dval;

  initial begin
    bus_clock_n_o = 1'b1;
    #3;
    forever #40 bus_clock_n_o = ~bus_clock_n_o;
  end

  // Emulation timing only: status pins, non-maskable entry and reset vector stay in the master
  initial begin
    {mcsync_n_o, memreq_n_o, rd_n_o, wr_n_o, refresh_n_o, busak_n_o, intak_n_o} = 7'h7f;
    addr_o = 16'h0000;
    dval = 8'h00;
    den = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge bus_clock_n_o);
  endtask

  task automatic mem_cycle(input logic [19:0] a, input logic wr, input logic [7:0] wd,
                           output logic [7:0] rd);
    int w;
    tick(1);
    addr_o = a[15:0];
    dval = {4'h0, a[19:16]};
    den = 1'b1;
    mcsync_n_o = 1'b0;
    tick(1);
    mcsync_n_o = 1'b1;
    memreq_n_o = 1'b0;
    dval = wd;
    den = wr;
    wr_n_o = ~wr;
    rd_n_o = wr;
    tick(2);
    for (w = 0; w < 16 && waitrq_n_i !== 1'b1; w++) tick(1);
    rd = data_i;
    {memreq_n_o, rd_n_o, wr_n_o} = 3'h7;
    den = 1'b0;
    tick(1);
  endtask

  task automatic refresh(input logic [7:0] row);
    tick(1);
    addr_o = {~row, row};
    refresh_n_o = 1'b0;
    memreq_n_o = 1'b0;
    tick(2);
    refresh_n_o = 1'b1;
    memreq_n_o = 1'b1;
    tick(1);
  endtask

  task automatic int_ack(output logic [7:0] v);
    tick(1);
    intak_n_o = 1'b0;
    tick(2);
    v = data_i;
    intak_n_o = 1'b1;
    tick(1);
  endtask

  // Cycles are sequential, so the current one is always over before the grant
  task automatic set_busak(input logic on);
    tick(1);
    busak_n_o = ~on;
  endtask
endmodule
`default_nettype wire

// ---- testbench/sbc_card_tb.sv ----
// Self-checking bench for the memory card front end.
// Assumes the CPU card model for the far side; card-side inputs change on clk falling edge.
`timescale 1ns/1ps
`default_nettype none
module sbc_card_tb;
  import sbc_pkg::*;
  logic        clk_i, resetn_i, card_en, irq, sdone, dma, pci;
  logic        mcsync_n, memreq_n, rd_n, wr_n, refresh_n, bclk_n, busak_n, intak_n;
  logic        data_oe_o, waitrq_n_o, waitrq_oe_o, intrq_n_o, intrq_oe_o, pco_o, bus_grant_o;
  logic        refresh_pulse_o;
  logic [1:0]  page_sel;
  logic [7:0]  cpu_data, card_data, bus_data, vector, refresh_row_o;
  logic [15:0] addr;
  int          error_cnt, n_compared, ref_cnt, oe_cnt, wait_cnt;

  assign bus_data = data_oe_o ? card_data : cpu_data;
  wire waitrq_n = waitrq_oe_o ? waitrq_n_o : 1'b1;

  sbc_card #(.MEM_ADDR_W(12)) sbc_card_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr), .data_i(bus_data),
    .data_o(card_data), .data_oe_o(data_oe_o), .mcsync_n_i(mcsync_n),
    .memreq_n_i(memreq_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .refresh_n_i(refresh_n),
    .bus_clock_n_i(bclk_n), .busak_n_i(busak_n), .intak_n_i(intak_n),
    .waitrq_n_o(waitrq_n_o), .waitrq_oe_o(waitrq_oe_o), .intrq_n_o(intrq_n_o),
    .intrq_oe_o(intrq_oe_o), .pci_i(pci), .pco_o(pco_o), .card_en_i(card_en),
    .page_sel_i(page_sel), .irq_i(irq), .vector_i(vector), .service_done_i(sdone),
    .dma_req_i(dma), .bus_grant_o(bus_grant_o), .refresh_pulse_o(refresh_pulse_o),
    .refresh_row_o(refresh_row_o));

  sbc_cpu_model sbc_cpu_model_inst (
    .bus_clock_n_o(bclk_n), .addr_o(addr), .data_o(cpu_data), .mcsync_n_o(mcsync_n),
    .memreq_n_o(memreq_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .refresh_n_o(refresh_n),
    .busak_n_o(busak_n), .intak_n_o(intak_n), .data_i(bus_data), .waitrq_n_i(waitrq_n));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (refresh_pulse_o === 1'b1) ref_cnt++;
    if (data_oe_o === 1'b1) oe_cnt++;
    if (waitrq_oe_o === 1'b1) wait_cnt++;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp, input logic [7:0] nw);
    logic [7:0] got;
    int w0, o0;
    w0 = wait_cnt;
    o0 = oe_cnt;
    sbc_cpu_model_inst.mem_cycle(a, 1'b0, 8'h00, got);
    if (nw != 8'h00) check("read data", exp, got);
    check("wait pulses", nw, 8'(wait_cnt - w0));
    if (nw == 8'h00) check("miss drives", 8'h00, 8'(oe_cnt - o0));
  endtask

  task automatic t_rw();
    logic [7:0] x;
    sbc_cpu_model_inst.mem_cycle(20'hb0123, 1'b1, 8'h5a, x);
    sbc_cpu_model_inst.mem_cycle(20'hb0456, 1'b1, 8'ha5, x);
    rd_chk(20'hb0123, 8'h5a, 8'h01);
    rd_chk(20'hb0456, 8'ha5, 8'h01);
    rd_chk(20'h70123, 8'h00, 8'h00);
    @(negedge clk_i) card_en = 1'b0;
    rd_chk(20'hb0123, 8'h00, 8'h00);
    @(negedge clk_i) card_en = 1'b1;
    $display("t_rw done");
  endtask

  task automatic t_refresh();
    int r0;
    for (int i = 0; i < 2; i++) begin
      r0 = ref_cnt;
      sbc_cpu_model_inst.refresh(8'h3c ^ {8{i[0]}});
      check("refresh pulses", 8'h01, 8'(ref_cnt - r0));
      check("refresh row", 8'h3c ^ {8{i[0]}}, refresh_row_o);
    end
    $display("t_refresh done");
  endtask

  task automatic t_irq();
    logic [7:0] v;
    int o0;
    @(negedge clk_i);
    vector = 8'h96;
    irq = 1'b1;
    repeat (8) @(negedge clk_i);
    check("chain out idle", 8'h01, {7'h0, pco_o});
    check("request", 8'h01, {7'h0, intrq_oe_o});
    check("request level", 8'h00, {7'h0, intrq_n_o});
    sbc_cpu_model_inst.int_ack(v);
    check("vector", 8'h96, v);
    repeat (4) @(negedge clk_i);
    check("chain out served", 8'h00, {7'h0, pco_o});
    check("request served", 8'h00, {7'h0, intrq_oe_o});
    sdone = 1'b1;
    @(negedge clk_i) sdone = 1'b0;
    pci = 1'b0;
    repeat (8) @(negedge clk_i);
    check("chain out blocked", 8'h00, {7'h0, pco_o});
    check("request blocked", 8'h00, {7'h0, intrq_oe_o});
    o0 = oe_cnt;
    sbc_cpu_model_inst.int_ack(v);
    check("blocked drives", 8'h00, 8'(oe_cnt - o0));
    @(negedge clk_i) pci = 1'b1;
    irq = 1'b0;
    repeat (8) @(negedge clk_i);
    check("chain out back", 8'h01, {7'h0, pco_o});
    $display("t_irq done");
  endtask

  task automatic t_grant();
    @(negedge clk_i) dma = 1'b1;
    sbc_cpu_model_inst.set_busak(1'b1);
    repeat (8) @(negedge clk_i);
    check("grant", 8'h01, {7'h0, bus_grant_o});
    dma = 1'b0;
    repeat (8) @(negedge clk_i);
    check("grant no request", 8'h00, {7'h0, bus_grant_o});
    dma = 1'b1;
    sbc_cpu_model_inst.set_busak(1'b0);
    repeat (8) @(negedge clk_i);
    check("grant released", 8'h00, {7'h0, bus_grant_o});
    @(negedge clk_i) dma = 1'b0;
    $display("t_grant done");
  endtask

  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Whole run is about 4.3 us; a hang is cut well past that
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    {error_cnt, n_compared, ref_cnt, oe_cnt, wait_cnt} = '0;
    {resetn_i, irq, sdone, dma} = 4'h0;
    {card_en, pci} = 2'h3;
    page_sel = 2'h2;
    vector = 8'h00;
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (8) @(negedge clk_i);
    t_rw();
    t_refresh();
    t_irq();
    t_grant();
    wrap_up();
  end
endmodule
`default_nettype wire
